// ===== shared/pld_pkg.sv
// Purpose: Shared constants and types of the logic block fabric.
// Assumes: APB with 32-bit data, 12-bit byte addresses.
// Notes:   Every register takes one aligned word.

package pld_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int N_IN   = 22;  // Array inputs from the switch matrix
   localparam int N_LPT  = 64;  // Logic product terms
   localparam int N_SPT  = 4;   // Special product terms
   localparam int N_PT   = 68;
   localparam int N_MC   = 16;  // Macrocells, even ones drive I/O cells
   localparam int N_CL   = 16;  // Clusters of four terms
   localparam int N_IOC  = 8;   // I/O cells of this block
   localparam int N_PIN  = 32;  // I/O pins of the device
   localparam int N_DED  = 4;   // Dedicated input pins
   localparam int N_CKP  = 2;   // Clock pins, also usable as inputs
   localparam int N_SRC  = 54;  // Switch matrix sources
   localparam int N_EXT  = 74;  // Synchronised outside signals

   // Switch matrix source bases
   localparam int SRC_DED = 32;
   localparam int SRC_CKP = 36;
   localparam int SRC_FB  = 38;

   // Special term indices
   localparam int PT_OE0  = 64;
   localparam int PT_ARST = 66;
   localparam int PT_APRE = 67;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STAT = 12'h004;
   localparam logic [11:0] OFS_TRUE = 12'h100;
   localparam logic [11:0] OFS_COMP = 12'h300;
   localparam logic [11:0] OFS_MC   = 12'h500;
   localparam logic [11:0] OFS_CL   = 12'h540;
   localparam logic [11:0] OFS_IOC  = 12'h580;
   localparam logic [11:0] OFS_SEL  = 12'h5C0;

   localparam int CTRL_RUN_BIT = 0;
   localparam int STAT_OE_LSB  = 16;

   localparam logic        CTRL_RST    = 1'b0;
   localparam logic [21:0] MASK_RST    = 22'h00_0000;
   localparam logic [5:0]  MC_CFG_RST  = 6'h00;
   localparam logic [1:0]  CL_RST      = 2'h2;
   localparam logic [2:0]  IOC_CFG_RST = 3'h1;
   localparam logic [5:0]  SEL_RST     = 6'h00;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {MODE_COMB, MODE_REG, MODE_LATCH} mc_mode_t;
   typedef enum logic [1:0] {OE_ALWAYS, OE_NEVER, OE_TERM} oe_mode_t;

   typedef struct packed {
      logic     in_reg;   // Buried only: capture the paired pin
      logic     clk_sel;  // Clock or gate pin 0 or 1
      logic     invert;
      logic     t_type;
      mc_mode_t mode;
   } mc_cfg_t;

   typedef struct packed {
      logic     pt_sel;
      oe_mode_t oe_mode;
   } ioc_cfg_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

endpackage : pld_pkg

// ===== design/pld_block.sv
// Purpose: One logic block of a small programmable device with its
//          switch matrix, configured over APB.
// Assumes: Pins and clock pins are sampled on sys_clk_i.
// Notes:   Clock pins clock registers through edge detection on the system clock; latches use their level as the gate.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.

`timescale 1ns/1ps

module pld_block (
   input  wire logic               sys_clk_i,
   input  wire logic               rst_b_i,
   input  wire pld_pkg::apb_req_t  apb_i,
   output logic                    pready_o,
   output logic [31:0]             prdata_o,
   output logic                    pslverr_o,
   input  wire logic [31:0]        pin_i,
   input  wire logic [31:0]        pin_drv_i,
   input  wire logic [3:0]         ded_i,
   input  wire logic [3:0]         ded_drv_i,
   input  wire logic [1:0]         ckp_i,
   output logic [31:0]             pin_o,
   output logic [31:0]             pin_oe_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic                 rst_meta;
   logic                 rst_n;
   logic [73:0]          ext_m;
   logic [73:0]          ext_s;
   logic [1:0]           ck_d;
   logic [35:0]          hold;
   logic [53:0]          src;
   logic [21:0]          arr_in;
   logic [67:0]          pt;
   logic [15:0]          cl_or;
   logic [15:0]          sum;
   logic [15:0]          d_in;
   logic [15:0]          edge_hit;
   logic [15:0]          gate;
   logic [15:0]          q;
   logic [15:0]          mc_out;
   logic                 run;
   logic                 arst;
   logic                 apre;
   logic [21:0]          true_mask [0:67];
   logic [21:0]          comp_mask [0:67];
   pld_pkg::mc_cfg_t     mc_cfg    [0:15];
   logic [1:0]           cl_steer  [0:15];
   pld_pkg::ioc_cfg_t    ioc_cfg   [0:7];
   logic [5:0]           sel       [0:21];
   logic                 setup;
   logic                 wr_ok;
   logic                 bad;
   logic [31:0]          rd_val;
   logic [2:0]           max_cl;

   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] base, input int n);
      hit = (int'(a) >= int'(base)) && (int'(a) < int'(base) + 4 * n);
   endfunction : hit

   function automatic int idx(input logic [11:0] a,
                              input logic [11:0] base);
      idx = (int'(a) - int'(base)) / 4;
   endfunction : idx

   // Macrocell reached by cluster k with steering code s, or -1
   function automatic int cl_target(input int k, input logic [1:0] s);
      int t;
      t = k - 2 + int'(s);
      cl_target = (t >= 0 && t < pld_pkg::N_MC) ? t : -1;
   endfunction : cl_target

   // ----------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ext_m <= '0;
         ext_s <= '0;
         ck_d  <= '0;
      end else begin
         ext_m <= {ckp_i, ded_drv_i, ded_i, pin_drv_i, pin_i};
         ext_s <= ext_m;
         ck_d  <= ext_s[73:72];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         hold <= '0;
      end else begin
         for (int p = 0; p < pld_pkg::N_PIN; p++) begin
            if (pin_oe_o[p]) begin
               hold[p] <= pin_o[p];
            end else if (ext_s[32 + p]) begin
               hold[p] <= ext_s[p];
            end
         end
         for (int p = 0; p < pld_pkg::N_DED; p++) begin
            if (ext_s[68 + p]) begin
               hold[32 + p] <= ext_s[64 + p];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Switch matrix, array and allocator
   // ----------------------------------------------------------------
   // matrix sources
   assign src = {mc_out, ext_s[73:72], hold};

   always_comb begin
      for (int i = 0; i < pld_pkg::N_IN; i++) begin
         arr_in[i] = (int'(sel[i]) < pld_pkg::N_SRC) ? src[sel[i]] : 1'b0;
      end
   end

   always_comb begin
      for (int t = 0; t < pld_pkg::N_PT; t++) begin
         pt[t] = (|(true_mask[t] | comp_mask[t])) &&
                 (&((arr_in | ~true_mask[t]) & (~arr_in | ~comp_mask[t])));
      end
   end

   assign arst = pt[pld_pkg::PT_ARST];
   assign apre = pt[pld_pkg::PT_APRE];

   always_comb begin
      for (int k = 0; k < pld_pkg::N_CL; k++) begin
         cl_or[k] = |pt[4 * k +: 4];
      end
      sum = '0;
      for (int m = 0; m < pld_pkg::N_MC; m++) begin
         for (int k = 0; k < pld_pkg::N_CL; k++) begin
            if (cl_target(k, cl_steer[k]) == m) begin
               sum[m] = sum[m] | cl_or[k];
            end
         end
      end
   end

   always_comb begin
      int c;
      c = 0;
      max_cl = '0;
      for (int m = 0; m < pld_pkg::N_MC; m++) begin
         c = 0;
         for (int k = 0; k < pld_pkg::N_CL; k++) begin
            if (cl_target(k, cl_steer[k]) == m) begin
               c = c + 1;
            end
         end
         if (c > int'(max_cl)) begin
            max_cl = 3'(c);
         end
      end
   end

   // ----------------------------------------------------------------
   // Macrocells
   // ----------------------------------------------------------------
   // clock select
   always_comb begin
      for (int m = 0; m < pld_pkg::N_MC; m++) begin
         gate[m]     = ext_s[72 + int'(mc_cfg[m].clk_sel)];
         edge_hit[m] = gate[m] && !ck_d[mc_cfg[m].clk_sel];
         d_in[m]     = (mc_cfg[m].in_reg && m[0]) ? hold[m >> 1] : sum[m];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else if (!run || arst) begin
         q <= '0;
      end else if (apre) begin
         q <= '1;
      end else begin
         for (int m = 0; m < pld_pkg::N_MC; m++) begin
            unique case (mc_cfg[m].mode)
               pld_pkg::MODE_REG: begin
                  if (edge_hit[m]) begin
                     q[m] <= mc_cfg[m].t_type ? q[m] ^ d_in[m] : d_in[m];
                  end
               end
               pld_pkg::MODE_LATCH: begin
                  if (!gate[m]) begin
                     q[m] <= d_in[m];
                  end
               end
               default: begin
                  q[m] <= q[m];
               end
            endcase
         end
      end
   end

   always_comb begin
      for (int m = 0; m < pld_pkg::N_MC; m++) begin
         mc_out[m] = ((mc_cfg[m].mode == pld_pkg::MODE_COMB) ? sum[m] : q[m])
                     ^ mc_cfg[m].invert;
      end
   end

   // ----------------------------------------------------------------
   // I/O cells
   // ----------------------------------------------------------------
   // output macrocell to I/O cell
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_o    <= '0;
         pin_oe_o <= '0;
      end else begin
         for (int p = 0; p < pld_pkg::N_IOC; p++) begin
            pin_o[p] <= mc_out[2 * p];
            unique case (ioc_cfg[p].oe_mode)
               pld_pkg::OE_ALWAYS: pin_oe_o[p] <= run;
               pld_pkg::OE_TERM:   pin_oe_o[p] <= run &&
                  pt[pld_pkg::PT_OE0 + int'(ioc_cfg[p].pt_sel)];
               default:            pin_oe_o[p] <= 1'b0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   assign setup     = apb_i.psel && !apb_i.penable;
   assign pready_o  = apb_i.psel && apb_i.penable;
   assign pslverr_o = pready_o && bad;
   assign wr_ok     = pready_o && apb_i.pwrite && !bad;

   always_comb begin
      int i;
      logic [11:0] a;
      i      = 0;
      a      = apb_i.paddr;
      bad    = (a[1:0] != 2'b00);
      rd_val = '0;
      if (a == pld_pkg::OFS_CTRL) begin
         rd_val[pld_pkg::CTRL_RUN_BIT] = run;
      end else if (a == pld_pkg::OFS_STAT) begin
         rd_val = {8'h00, pin_oe_o[7:0], mc_out};
         bad    = bad || apb_i.pwrite;
      end else begin
         if (hit(a, pld_pkg::OFS_TRUE, pld_pkg::N_PT)) begin
            rd_val = 32'(true_mask[idx(a, pld_pkg::OFS_TRUE)]);
         end else if (hit(a, pld_pkg::OFS_COMP, pld_pkg::N_PT)) begin
            rd_val = 32'(comp_mask[idx(a, pld_pkg::OFS_COMP)]);
         end else if (hit(a, pld_pkg::OFS_MC, pld_pkg::N_MC)) begin
            rd_val = 32'(mc_cfg[idx(a, pld_pkg::OFS_MC)]);
         end else if (hit(a, pld_pkg::OFS_CL, pld_pkg::N_CL)) begin
            rd_val = 32'(cl_steer[idx(a, pld_pkg::OFS_CL)]);
         end else if (hit(a, pld_pkg::OFS_IOC, pld_pkg::N_IOC)) begin
            rd_val = 32'(ioc_cfg[idx(a, pld_pkg::OFS_IOC)]);
         end else if (hit(a, pld_pkg::OFS_SEL, pld_pkg::N_IN)) begin
            rd_val = 32'(sel[idx(a, pld_pkg::OFS_SEL)]);
         end else begin
            bad = 1'b1;
         end
         bad = bad || (apb_i.pwrite && run);
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         prdata_o <= '0;
      end else if (setup) begin
         prdata_o <= rd_val;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         run <= pld_pkg::CTRL_RST;
      end else if (wr_ok && apb_i.paddr == pld_pkg::OFS_CTRL) begin
         run <= apb_i.pwdata[pld_pkg::CTRL_RUN_BIT];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         for (int t = 0; t < pld_pkg::N_PT; t++) begin
            true_mask[t] <= pld_pkg::MASK_RST;
            comp_mask[t] <= pld_pkg::MASK_RST;
         end
         for (int m = 0; m < pld_pkg::N_MC; m++) begin
            mc_cfg[m]   <= pld_pkg::mc_cfg_t'(pld_pkg::MC_CFG_RST);
            cl_steer[m] <= pld_pkg::CL_RST;
         end
         for (int p = 0; p < pld_pkg::N_IOC; p++) begin
            ioc_cfg[p] <= pld_pkg::ioc_cfg_t'(pld_pkg::IOC_CFG_RST);
         end
         for (int i = 0; i < pld_pkg::N_IN; i++) begin
            sel[i] <= pld_pkg::SEL_RST;
         end
      end else if (wr_ok) begin
         if (hit(apb_i.paddr, pld_pkg::OFS_TRUE, pld_pkg::N_PT)) begin
            true_mask[idx(apb_i.paddr, pld_pkg::OFS_TRUE)] <=
               apb_i.pwdata[21:0];
         end
         if (hit(apb_i.paddr, pld_pkg::OFS_COMP, pld_pkg::N_PT)) begin
            comp_mask[idx(apb_i.paddr, pld_pkg::OFS_COMP)] <=
               apb_i.pwdata[21:0];
         end
         if (hit(apb_i.paddr, pld_pkg::OFS_MC, pld_pkg::N_MC)) begin
            mc_cfg[idx(apb_i.paddr, pld_pkg::OFS_MC)] <=
               pld_pkg::mc_cfg_t'(apb_i.pwdata[5:0]);
         end
         if (hit(apb_i.paddr, pld_pkg::OFS_CL, pld_pkg::N_CL)) begin
            cl_steer[idx(apb_i.paddr, pld_pkg::OFS_CL)] <= apb_i.pwdata[1:0];
         end
         if (hit(apb_i.paddr, pld_pkg::OFS_IOC, pld_pkg::N_IOC)) begin
            ioc_cfg[idx(apb_i.paddr, pld_pkg::OFS_IOC)] <=
               pld_pkg::ioc_cfg_t'(apb_i.pwdata[2:0]);
         end
         if (hit(apb_i.paddr, pld_pkg::OFS_SEL, pld_pkg::N_IN)) begin
            sel[idx(apb_i.paddr, pld_pkg::OFS_SEL)] <= apb_i.pwdata[5:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n);

   a_reset_wins_all: assert property (run && arst |=> q == '0)
      else $error("Reset term did not clear all macrocells");
   a_preset_all_ones: assert property (run && !arst && apre |=> q == '1)
      else $error("Preset term did not set all macrocells");
   a_dtype_capture: assert property (run && !arst && !apre && edge_hit[0]
      && mc_cfg[0].mode == pld_pkg::MODE_REG && !mc_cfg[0].t_type
      |=> q[0] == $past(d_in[0]))
      else $error("D register missed its clock edge");
   a_toggle_flip: assert property (run && !arst && !apre && edge_hit[0]
      && mc_cfg[0].mode == pld_pkg::MODE_REG && mc_cfg[0].t_type && d_in[0]
      |=> q[0] != $past(q[0]))
      else $error("Toggle register did not invert");
   a_latch_hold: assert property (run && !arst && !apre && gate[0]
      && mc_cfg[0].mode == pld_pkg::MODE_LATCH |=> $stable(q[0]))
      else $error("Latch changed while gate high");
   a_oe_never_off: assert property (
      ioc_cfg[0].oe_mode == pld_pkg::OE_NEVER |=> !pin_oe_o[0])
      else $error("Disabled I/O cell drove its pin");
   a_locked_write: assert property (pready_o && apb_i.pwrite && run
      && apb_i.paddr != pld_pkg::OFS_CTRL |-> pslverr_o)
      else $error("Configuration write accepted while running");
   a_term_cap: assert property (max_cl <= 3'h4)
      else $error("Macrocell given more than sixteen terms");
   a_pin_keeper: assert property (!pin_oe_o[0] && !ext_s[32] ##1
      !pin_oe_o[0] && !ext_s[32] |-> $stable(hold[0]))
      else $error("Undriven pin did not hold its level");

   c_toggle_run: cover property (run && edge_hit[0] && mc_cfg[0].t_type);
   c_preset_hit: cover property (run && apre && !arst);
   c_latch_open: cover property (run && !gate[0]
      && mc_cfg[0].mode == pld_pkg::MODE_LATCH);
   c_pin_driven: cover property (pin_oe_o[0] ##1 !pin_oe_o[0]);

endmodule : pld_block

// ===== verif/board_model.sv
// Purpose: Board logic driving the I/O and dedicated input pins.
// Assumes: Bench sets wanted levels right after a rising edge.
// Notes:   A released pin shows the inverse of its last driven level.

`timescale 1ns/1ps

module board_model (
   input  wire logic        sys_clk_i,
   input  wire logic [35:0] lvl_i,
   input  wire logic [35:0] drv_i,
   input  wire logic [35:0] dev_oe_i,
   output logic      [35:0] lvl_o,
   output logic      [35:0] drv_o
);
   // ------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------
   logic [35:0] last    = '0;
   logic [35:0] pin_drv = '0;
   logic [35:0] pin_lvl = '1;
   logic [35:0] on;

   // Back off wherever the device drives the pin
   assign on    = drv_i & ~dev_oe_i;
   assign drv_o = pin_drv;
   assign lvl_o = pin_lvl;

   always @(posedge sys_clk_i) begin
      last    <= (on & lvl_i) | (~on & last);
      pin_drv <= on;
      pin_lvl <= (on & lvl_i) | (~on & ~last);
   end
endmodule : board_model

// ===== verif/pld_block_tb.sv
// Purpose: Self-checking bench of the logic block over APB and pins.
// Assumes: Pin changes reach pin_o within eight system clock edges.
// Notes:   Pin 8 feeds array input 0, ded 0 and 1 inputs 1 and 2.

`timescale 1ns/1ps

module pld_block_tb;
   logic              sys_clk = 1'b0;
   logic              rst_b   = 1'b0;
   pld_pkg::apb_req_t apb     = '0;
   logic              pready;
   logic       [31:0] prdata;
   logic              pslverr;
   logic       [31:0] lvl     = '0;
   logic       [31:0] drv     = 32'h0000_0100;
   logic        [3:0] dlvl    = 4'h0;
   logic        [3:0] ddrv    = 4'hF;
   logic        [1:0] ckp     = 2'h0;
   logic       [35:0] b_lvl;
   logic       [35:0] b_drv;
   logic       [31:0] pout;
   logic       [31:0] poe;
   logic       [31:0] rd;
   logic              err;
   logic              v;
   int                mismatches = 0;
   int                compares   = 0;
   int                cyc        = 0;
   int                oe_exp [4] = '{1, 0, 1, 0};
   logic       [31:0] oe_cfg [4] = '{0, 1, 2, 6};

   pld_block pld_block_inst (
      .sys_clk_i(sys_clk), .rst_b_i(rst_b), .apb_i(apb),
      .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
      .pin_i(b_lvl[31:0]), .pin_drv_i(b_drv[31:0]),
      .ded_i(b_lvl[35:32]), .ded_drv_i(b_drv[35:32]),
      .ckp_i(ckp), .pin_o(pout), .pin_oe_o(poe));

   board_model board_model_inst (
      .sys_clk_i(sys_clk), .lvl_i({dlvl, lvl}), .drv_i({ddrv, drv}),
      .dev_oe_i({4'h0, poe}), .lvl_o(b_lvl), .drv_o(b_drv));

   always #25 sys_clk = ~sys_clk;

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] s,
                      input logic [31:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      @(posedge sys_clk);
      apb <= '{1'b1, 1'b0, w, a, d};
      @(posedge sys_clk);
      apb.penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      apb <= '0;
   endtask : xfer

   task automatic cfg(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, pld_pkg::OFS_CTRL, 32'h0000_0000);
      xfer(1'b1, a, d);
      xfer(1'b1, pld_pkg::OFS_CTRL, 32'h0000_0001);
   endtask : cfg

   task automatic settle;
      repeat (8) @(posedge sys_clk);
   endtask : settle

   task automatic pin8(input logic b);
      @(posedge sys_clk);
      lvl[8] <= b;
      settle();
   endtask : pin8

   task automatic pulse(input int k);
      @(posedge sys_clk);
      ckp[k] <= 1'b1;
      repeat (3) @(posedge sys_clk);
      ckp[k] <= 1'b0;
      settle();
   endtask : pulse

   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         end_sim();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      v = 1'($urandom(32'he534_a8d1));
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
      xfer(1'b0, pld_pkg::OFS_CL + 12'h014, '0);
      chk("cl5", rd, 32'h0000_0002);
      xfer(1'b0, pld_pkg::OFS_IOC + 12'h00C, '0);
      chk("ioc3", rd, 32'h0000_0001);
      chk("oe_rst", poe, 32'h0000_0000);
      xfer(1'b1, pld_pkg::OFS_STAT, 32'h0000_0001);
      chk("stat_wr", 32'(err), 32'h0000_0001);
      xfer(1'b0, 12'hFFC, '0);
      chk("unmap", {rd[30:0], err}, 32'h0000_0001);
      $display("test reset and refusal done");
      xfer(1'b1, pld_pkg::OFS_SEL, 32'h0000_0008);
      xfer(1'b1, pld_pkg::OFS_SEL + 12'h004, 32'h0000_0020);
      xfer(1'b1, pld_pkg::OFS_SEL + 12'h008, 32'h0000_0021);
      xfer(1'b1, pld_pkg::OFS_TRUE, 32'h0000_0001);
      xfer(1'b1, 12'h208, 32'h0000_0002);
      xfer(1'b1, 12'h20C, 32'h0000_0004);
      xfer(1'b1, 12'h200, 32'h0000_0004);
      cfg(pld_pkg::OFS_IOC, 32'h0000_0000);
      xfer(1'b1, pld_pkg::OFS_MC, 32'h0000_0001);
      chk("lock", 32'(err), 32'h0000_0001);
      for (int i = 0; i < 8; i++) begin
         v = 1'($urandom);
         pin8(v);
         chk("comb", 32'(pout[0]), 32'(v));
      end
      pin8(1'b1);
      @(posedge sys_clk);
      drv[8] <= 1'b0;
      settle();
      chk("keep", 32'(pout[0]), 32'h0000_0001);
      drv[8] <= 1'b1;
      cfg(pld_pkg::OFS_MC, 32'h0000_0008);
      pin8(v);
      chk("inv", 32'(pout[0]), 32'(!v));
      $display("test comb done");
      cfg(pld_pkg::OFS_MC, 32'h0000_0001);
      pin8(1'b1);
      chk("d_idle", 32'(pout[0]), 32'h0000_0000);
      pulse(0);
      chk("d_one", 32'(pout[0]), 32'h0000_0001);
      pin8(1'b0);
      chk("d_hold", 32'(pout[0]), 32'h0000_0001);
      pulse(0);
      chk("d_zero", 32'(pout[0]), 32'h0000_0000);
      cfg(pld_pkg::OFS_MC, 32'h0000_0015);
      pin8(1'b1);
      pulse(0);
      chk("other_ck", 32'(pout[0]), 32'h0000_0000);
      pulse(1);
      chk("t_one", 32'(pout[0]), 32'h0000_0001);
      pulse(1);
      chk("t_zero", 32'(pout[0]), 32'h0000_0000);
      pulse(1);
      @(posedge sys_clk);
      dlvl <= 4'h3;
      settle();
      chk("arst", 32'(pout[0]), 32'h0000_0000);
      dlvl[0] <= 1'b0;
      settle();
      chk("apre", 32'(pout[0]), 32'h0000_0001);
      dlvl[1] <= 1'b0;
      $display("test register done");
      cfg(pld_pkg::OFS_MC, 32'h0000_0002);
      pin8(v);
      chk("lat_open", 32'(pout[0]), 32'(v));
      @(posedge sys_clk);
      ckp[0] <= 1'b1;
      settle();
      pin8(~v);
      chk("lat_hold", 32'(pout[0]), 32'(v));
      ckp[0] <= 1'b0;
      $display("test latch done");
      cfg(pld_pkg::OFS_MC + 12'h004, 32'h0000_0021);
      settle();
      pulse(0);
      xfer(1'b0, pld_pkg::OFS_STAT, '0);
      chk("in_reg", 32'(rd[1]), 32'(!v));
      $display("test input register done");
      dlvl[1] <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         cfg(pld_pkg::OFS_IOC, oe_cfg[m]);
         settle();
         chk("oe", 32'(poe[0]), 32'(oe_exp[m]));
      end
      $display("test output enable done");
      end_sim();
   end
endmodule : pld_block_tb
